//--- core/temp_limit_map.svh
`ifndef TEMP_LIMIT_MAP_SVH
`define TEMP_LIMIT_MAP_SVH

// register word offsets on the register port
`define OFS_TEMPERATURE_RESULT 3'h2
`define OFS_IDENTIFICATION 3'h3
`define OFS_CRITICAL_LIMIT 3'h4
`define OFS_HYSTERESIS_SETTING 3'h5
`define OFS_HIGH_LIMIT 3'h6
`define OFS_LOW_LIMIT 3'h7

// reset values
`define RST_TEMPERATURE_RESULT 16'h0000
`define RST_CRITICAL_LIMIT 16'h4980
`define RST_HYSTERESIS_SETTING 8'h05
`define RST_HIGH_LIMIT 16'h2000
`define RST_LOW_LIMIT 16'h0500

// result word field positions
`define POS_SIGN 15
`define POS_FLAG_CRIT 2
`define POS_FLAG_HIGH 1
`define POS_FLAG_LOW 0
// mask that keeps bits 15:3 of a 13-bit result
`define MASK_13BIT 16'hFFF8

// identification field positions
`define POS_MAKER_LSB 3
`define POS_REV_LSB 0

// hysteresis field width and weight (one degree is 128 lsb of 0.0078 C)
`define HYST_FIELD_MSB 3
`define HYST_DEGREE_SHIFT 7

`endif

//--- core/temp_limit_pkg.sv
`include "temp_limit_map.svh"

package temp_limit_pkg;

  // one access on the register port
  typedef struct packed {
    logic [2:0] addr;
    logic wr_en;
    logic rd_en;
    logic [15:0] wr_data;
  } reg_req_t;

  // writable setpoints
  typedef struct packed {
    logic [15:0] critical_limit;
    logic [7:0] hysteresis_setting;
    logic [15:0] high_limit;
    logic [15:0] low_limit;
  } setpoint_t;

  // state of one threshold detector
  typedef struct packed {
    logic alarm;
  } detector_state_t;

  // state of the top module
  typedef struct packed {
    logic [15:0] temperature_result;
    logic [15:0] rd_data;
    logic rd_valid;
    logic critical_event;
    logic high_event;
    logic low_event;
    logic critical_alarm_output;
    logic limit_alarm_output;
  } top_state_t;

  // release threshold: limit moved by the hysteresis, 17 bits so it never wraps
  function automatic logic signed [16:0] release_level(input logic [15:0] limit,
                                                      input logic [3:0] hyst,
                                                      input logic add);
    logic signed [16:0] lim;
    logic signed [16:0] step;
    lim = {limit[15], limit};
    step = 17'(hyst) <<< `HYST_DEGREE_SHIFT;
    release_level = add ? 17'(lim + step) : 17'(lim - step);
  endfunction

endpackage

//--- core/setpoint_regs.sv
`timescale 1ns/1ps
`include "temp_limit_map.svh"
// holds the writable limit and hysteresis registers
module setpoint_regs
  import temp_limit_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire reg_req_t req,
  output setpoint_t setpoints
);

  setpoint_t state_reg; // registered setpoints
  setpoint_t state_next; // next setpoints

  ////////////////////////////////////////////////////////////////////////
  // write decode, one register per access
  always_comb begin
    state_next = state_reg;
    if (req.wr_en) begin
      case (req.addr)
        `OFS_CRITICAL_LIMIT: state_next.critical_limit = req.wr_data;
        `OFS_HYSTERESIS_SETTING: state_next.hysteresis_setting = req.wr_data[7:0];
        `OFS_HIGH_LIMIT: state_next.high_limit = req.wr_data;
        `OFS_LOW_LIMIT: state_next.low_limit = req.wr_data;
        default: state_next = state_reg; // read-only or unmapped: ignored
      endcase
    end
  end

  // register with documented reset values
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg.critical_limit <= `RST_CRITICAL_LIMIT;
      state_reg.hysteresis_setting <= `RST_HYSTERESIS_SETTING;
      state_reg.high_limit <= `RST_HIGH_LIMIT;
      state_reg.low_limit <= `RST_LOW_LIMIT;
    end else begin
      state_reg <= state_next;
    end
  end

  assign setpoints = state_reg;

endmodule

//--- core/threshold_detector.sv
`timescale 1ns/1ps
// one limit: instant event test plus an alarm that releases with hysteresis
module threshold_detector
  import temp_limit_pkg::*;
#(
  parameter bit LOW_SIDE = 1'b0
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sample_valid,
  input wire logic [15:0] sample,
  input wire logic [15:0] limit,
  input wire logic [3:0] hyst,
  output logic event_now,
  output logic alarm
);

  detector_state_t state_reg; // alarm held between conversions
  detector_state_t state_next; // next alarm
  logic signed [16:0] release_thr; // threshold that ends the alarm
  logic release_now; // sample is past the release threshold

  ////////////////////////////////////////////////////////////////////////
  // signed compare of the sample against the limit and release level
  always_comb begin
    release_thr = release_level(limit, hyst, LOW_SIDE);
    if (LOW_SIDE) begin
      event_now = $signed(sample) < $signed(limit);
      release_now = $signed({sample[15], sample}) > release_thr;
    end else begin
      event_now = $signed(sample) > $signed(limit);
      release_now = $signed({sample[15], sample}) < release_thr;
    end
    state_next = state_reg;
    if (sample_valid) begin
      if (event_now) begin
        state_next.alarm = 1'b1; // limit crossed
      end else if (release_now) begin
        state_next.alarm = 1'b0; // back past the hysteresis band
      end
    end
  end

  // alarm register, evaluated once per conversion
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign alarm = state_reg.alarm;

endmodule

//--- core/temperature_limit_registers.sv
`timescale 1ns/1ps
`include "temp_limit_map.svh"
// Function
// - result register at 0x02, signed 16 bits
// - low bits: flags at 13-bit, data at 16-bit
// - resolution select bit picks flag meaning
// - bit 0 set when below low limit
// - bit 1 set when above high limit
// - bit 2 set when above critical limit
// - id register at 0x03, maker and revision
// - above critical limit raises critical alarm output
// - critical limit read/write, resets to 0x4980
// - hysteresis register 0x05, four low bits
// - release levels shifted by the hysteresis
// - hysteresis resets to five, upper bits zero
// - above high limit raises limit alarm
// - high limit read/write, resets to 0x2000
// - below low limit raises limit alarm
// - low limit read/write, resets to 0x0500
// - sign in bit 15, result resets zero
// - lsb weighs 0.0625 or 0.0078 degrees
module temperature_limit_registers
  import temp_limit_pkg::*;
#(
  parameter logic [4:0] MAKER_ID = 5'h0A, // arbitrary value
  parameter logic [2:0] REVISION_ID = 3'h1 // arbitrary value
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic resolution_sel,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  output logic [15:0] reg_rd_data,
  output logic reg_rd_valid,
  output logic critical_event,
  output logic high_event,
  output logic low_event,
  output logic critical_alarm_output,
  output logic limit_alarm_output
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  top_state_t state_reg; // all registered state of this module
  top_state_t state_next; // next value of the state
  reg_req_t req; // bundled register access
  setpoint_t setpoints; // current writable setpoints
  logic [15:0] stored_temp; // conversion as it will be stored
  logic crit_now; // sample above critical limit
  logic high_now; // sample above high limit
  logic low_now; // sample below low limit
  logic crit_alarm; // critical alarm with hysteresis
  logic high_alarm; // overtemperature alarm with hysteresis
  logic low_alarm; // undertemperature alarm with hysteresis
  logic [15:0] result_word; // result word as it is written

  ////////////////////////////////////////////////////////////////////////
  // register port bundle

  // gather the access signals into one carrier
  always_comb begin
    req.addr = reg_addr;
    req.wr_en = reg_wr_en;
    req.rd_en = reg_rd_en;
    req.wr_data = reg_wr_data;
  end

  ////////////////////////////////////////////////////////////////////////
  // conversion sample

  // conversion input is 16 bits, lsb 0.0078 degrees; at 13 bits the
  // three low bits are dropped so the lsb weighs 0.0625 degrees
  always_comb begin
    if (resolution_sel) begin
      stored_temp = conv_data;
    end else begin
      stored_temp = conv_data & `MASK_13BIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // writable setpoints

  // critical, high, low and hysteresis registers
  setpoint_regs u_setpoints (
    .clk(clk),
    .sys_rst(sys_rst),
    .req(req),
    .setpoints(setpoints)
  );

  ////////////////////////////////////////////////////////////////////////
  // limit detectors

  // critical limit, releases below limit minus hysteresis
  threshold_detector #(
    .LOW_SIDE(1'b0)
  ) u_crit (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(conv_valid),
    .sample(stored_temp),
    .limit(setpoints.critical_limit),
    .hyst(setpoints.hysteresis_setting[`HYST_FIELD_MSB:0]),
    .event_now(crit_now),
    .alarm(crit_alarm)
  );

  // high limit, releases below limit minus hysteresis
  threshold_detector #(
    .LOW_SIDE(1'b0)
  ) u_high (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(conv_valid),
    .sample(stored_temp),
    .limit(setpoints.high_limit),
    .hyst(setpoints.hysteresis_setting[`HYST_FIELD_MSB:0]),
    .event_now(high_now),
    .alarm(high_alarm)
  );

  // low limit, releases above limit plus hysteresis
  threshold_detector #(
    .LOW_SIDE(1'b1)
  ) u_low (
    .clk(clk),
    .sys_rst(sys_rst),
    .sample_valid(conv_valid),
    .sample(stored_temp),
    .limit(setpoints.low_limit),
    .hyst(setpoints.hysteresis_setting[`HYST_FIELD_MSB:0]),
    .event_now(low_now),
    .alarm(low_alarm)
  );

  ////////////////////////////////////////////////////////////////////////
  // result word

  // low three bits are flags at 13 bits, extended data at 16 bits
  always_comb begin
    result_word = stored_temp;
    if (!resolution_sel) begin
      result_word[`POS_FLAG_CRIT] = crit_now;
      result_word[`POS_FLAG_HIGH] = high_now;
      result_word[`POS_FLAG_LOW] = low_now;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  // conversion update, alarm copy and read mux
  always_comb begin
    state_next = state_reg;
    state_next.rd_valid = 1'b0;
    // store the result and event flags once per conversion
    if (conv_valid) begin
      state_next.temperature_result = result_word;
      state_next.critical_event = crit_now;
      state_next.high_event = high_now;
      state_next.low_event = low_now;
    end
    // alarm pins follow the detectors with one register stage
    state_next.critical_alarm_output = crit_alarm;
    state_next.limit_alarm_output = high_alarm | low_alarm;
    // read answer one cycle after the request
    if (req.rd_en) begin
      state_next.rd_valid = 1'b1;
      case (req.addr)
        `OFS_TEMPERATURE_RESULT: begin
          state_next.rd_data = state_reg.temperature_result;
        end
        `OFS_IDENTIFICATION: begin
          state_next.rd_data = 16'({MAKER_ID, REVISION_ID});
        end
        `OFS_CRITICAL_LIMIT: begin
          state_next.rd_data = setpoints.critical_limit;
        end
        `OFS_HYSTERESIS_SETTING: begin
          state_next.rd_data = {8'h00, setpoints.hysteresis_setting};
        end
        `OFS_HIGH_LIMIT: begin
          state_next.rd_data = setpoints.high_limit;
        end
        `OFS_LOW_LIMIT: begin
          state_next.rd_data = setpoints.low_limit;
        end
        default: begin
          state_next.rd_data = 16'h0000; // registers outside this block read zero
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register

  // synchronous reset clears result, flags and alarms
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.temperature_result <= `RST_TEMPERATURE_RESULT;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign reg_rd_data = state_reg.rd_data;
  assign reg_rd_valid = state_reg.rd_valid;
  assign critical_event = state_reg.critical_event;
  assign high_event = state_reg.high_event;
  assign low_event = state_reg.low_event;
  assign critical_alarm_output = state_reg.critical_alarm_output;
  assign limit_alarm_output = state_reg.limit_alarm_output;

endmodule

//--- verification/temp_limit_checker_asserts.sv
`timescale 1ns/1ps
// watches the register port and the compare outputs of the limit block
module temp_limit_checker #(
  parameter logic [4:0] MAKER_ID = 5'h0A, // arbitrary value
  parameter logic [2:0] REVISION_ID = 3'h1 // arbitrary value
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [15:0] reg_wr_data,
  input wire logic resolution_sel,
  input wire logic conv_valid,
  input wire logic [15:0] conv_data,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid,
  input wire logic critical_event,
  input wire logic high_event,
  input wire logic low_event,
  input wire logic critical_alarm_output,
  input wire logic limit_alarm_output
);
  // one clock domain, reset disables every check
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////
  AST_RD_ANSWER: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe got no answer");
  AST_RD_QUIET: assert property (!reg_rd_en |=> !reg_rd_valid)
    else $error("answer without a read");
  AST_UNMAPPED: assert property (reg_rd_en && reg_addr < 3'h2 |=> reg_rd_data == 16'h0000)
    else $error("unmapped read not zero");
  AST_ID_READ: assert property (reg_rd_en && reg_addr == 3'h3 |=>
    reg_rd_data == {8'h00, MAKER_ID, REVISION_ID})
    else $error("identification read wrong");
  AST_EVENT_HOLD: assert property (!conv_valid |=> $stable({critical_event, high_event, low_event}))
    else $error("events moved without a conversion");
  AST_CRIT_SET: assert property ($rose(critical_event) |=> critical_alarm_output)
    else $error("critical alarm not raised");
  AST_HIGH_SET: assert property ($rose(high_event) |=> limit_alarm_output)
    else $error("limit alarm not raised on high");
  AST_LOW_SET: assert property ($rose(low_event) |=> limit_alarm_output)
    else $error("limit alarm not raised on low");
  // alarm pins trail the conversion strobe by two edges: detector stage, then output stage
  AST_ALARM_HOLD: assert property (!$past(conv_valid, 2) |->
    $stable({critical_alarm_output, limit_alarm_output}))
    else $error("alarm moved without a conversion");
endmodule
// attach the checker to every instance of the block
bind temperature_limit_registers temp_limit_checker #(.MAKER_ID(MAKER_ID), .REVISION_ID(REVISION_ID)) chk (
  .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
  .reg_wr_data(reg_wr_data), .resolution_sel(resolution_sel), .conv_valid(conv_valid),
  .conv_data(conv_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
  .critical_event(critical_event), .high_event(high_event), .low_event(low_event),
  .critical_alarm_output(critical_alarm_output), .limit_alarm_output(limit_alarm_output));

//--- verification/reg_host_model.sv
`timescale 1ns/1ps
// host side of the register port: one strobe per access
module reg_host_model (
  input wire logic clk,
  output logic [2:0] reg_addr,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output logic [15:0] reg_wr_data,
  input wire logic [15:0] reg_rd_data,
  input wire logic reg_rd_valid
);
  // idle port at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wr_data = 16'h0000;
  end
  ////////////////////////////////////////////////////////////
  // one-cycle write strobe, data scrambled once taken
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge clk) #1;
    reg_wr_en = 1'b0;
    reg_wr_data = ~d;
  endtask
  // one-cycle read strobe, answer sampled in the following cycle
  task automatic rd(input logic [2:0] a, output logic [15:0] d, output logic ok);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk) #1;
    reg_rd_en = 1'b0;
    ok = reg_rd_valid;
    d = reg_rd_data;
  endtask
endmodule

//--- verification/temperature_limit_registers_tb.sv
`timescale 1ns/1ps
// register, compare and alarm tests for the limit block
module temperature_limit_registers_tb;
  localparam logic [4:0] MK = 5'h13; // arbitrary value
  localparam logic [2:0] RV = 3'h5; // arbitrary value
  logic clk, sys_rst, resolution_sel, conv_valid; // bench driven controls
  logic [15:0] conv_data; // conversion word
  logic [2:0] reg_addr; // host driven port
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [15:0] reg_wr_data, reg_rd_data;
  logic critical_event, high_event, low_event, critical_alarm_output, limit_alarm_output;
  int n_mismatch = 0; // failed comparisons
  int total_checks = 0; // all comparisons
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, (a), (e)); end end
  ////////////////////////////////////////////////////////////
  temperature_limit_registers #(.MAKER_ID(MK), .REVISION_ID(RV)) dut (.clk(clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data),
    .resolution_sel(resolution_sel), .conv_valid(conv_valid), .conv_data(conv_data),
    .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .critical_event(critical_event),
    .high_event(high_event), .low_event(low_event), .critical_alarm_output(critical_alarm_output),
    .limit_alarm_output(limit_alarm_output));
  reg_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid));
  ////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // prints counts and verdict, ends the run
  task automatic conclude();
    $display("mismatches %0d checks %0d", n_mismatch, total_checks);
    if (n_mismatch == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // read one register and compare it
  task automatic check_reg(input logic [2:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic ok;
    host.rd(a, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask
  // one conversion pulse, then alarms, event levels {crit, high, low} and the stored result
  task automatic conv(input logic r, input logic [15:0] d, input logic [15:0] e, input logic ca, input logic la,
                      input logic [2:0] ev);
    @(posedge clk) #1;
    resolution_sel = r;
    conv_valid = 1'b1;
    conv_data = d;
    @(posedge clk) #1;
    conv_valid = 1'b0;
    conv_data = ~d;
    @(posedge clk) #1;
    `CHK(critical_alarm_output, ca)
    `CHK(limit_alarm_output, la)
    `CHK({critical_event, high_event, low_event}, ev)
    check_reg(3'h2, e);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    sys_rst = 1'b1;
    resolution_sel = 1'b0;
    conv_valid = 1'b0;
    conv_data = 16'h0000;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    check_reg(3'h4, 16'h4980);
    check_reg(3'h5, 16'h0005);
    check_reg(3'h6, 16'h2000);
    check_reg(3'h7, 16'h0500);
    check_reg(3'h2, 16'h0000);
    check_reg(3'h0, 16'h0000);
    host.wr(3'h2, 16'h1234);
    host.wr(3'h3, 16'hFFFF);
    check_reg(3'h2, 16'h0000);
    check_reg(3'h3, {8'h00, MK, RV});
    host.wr(3'h4, 16'h4000);
    host.wr(3'h5, 16'h00F5);
    host.wr(3'h6, 16'h7FFF);
    host.wr(3'h7, 16'h8001);
    check_reg(3'h4, 16'h4000);
    check_reg(3'h5, 16'h00F5);
    check_reg(3'h6, 16'h7FFF);
    check_reg(3'h7, 16'h8001);
    host.wr(3'h6, 16'h2000);
    host.wr(3'h7, 16'h0500);
    conv(1'b0, 16'h4A07, 16'h4A06, 1'b1, 1'b1, 3'b110);
    conv(1'b0, 16'h3E00, 16'h3E02, 1'b1, 1'b1, 3'b010);
    conv(1'b1, 16'h1C05, 16'h1C05, 1'b0, 1'b0, 3'b000);
    conv(1'b0, 16'h0400, 16'h0401, 1'b0, 1'b1, 3'b001);
    conv(1'b0, 16'h0700, 16'h0700, 1'b0, 1'b1, 3'b000);
    conv(1'b0, 16'h0800, 16'h0800, 1'b0, 1'b0, 3'b000);
    conv(1'b0, 16'hFF8F, 16'hFF89, 1'b0, 1'b1, 3'b001);
    conclude();
  end
  // cuts a hang short
  initial begin
    #20000;
    n_mismatch++;
    conclude();
  end
endmodule
